// file: esa_pkg.sv
// shared constants and types for the stack and address generator
package esa_pkg;

   // ------------------------------------------------------------
   // address boundaries and bit positions
   // ------------------------------------------------------------
   localparam int          WIN_BIT    = 15;         // ea bit that opens the window
   localparam int          PV_BIT     = 9;          // read page: program view select
   localparam int          UPPER_BIT  = 8;          // read page: upper word select
   localparam int          CFG_BIT    = 7;          // table page: configuration space
   localparam int          PV_PAGE_W  = 8;          // read page bits used by program view
   localparam logic [15:0] NEAR_TOP   = 16'h1fff;   // last near data address
   localparam logic [15:0] SFR_TOP    = 16'h0800;   // lowest legal stack address
   localparam logic [15:0] SP_RESET   = 16'h0800;   // stack pointer after reset
   localparam logic [15:0] WORD_STEP  = 16'h0002;   // one stack word in bytes
   localparam logic [15:0] WORD_MASK  = 16'hfffe;   // clears the byte bit
   localparam logic [7:0]  ZERO_BYTE  = 8'h00;
   localparam logic [9:0]  RPAGE_ZERO = 10'h000;
   localparam logic [8:0]  WPAGE_ZERO = 9'h000;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_READ, OP_WRITE, OP_PUSH, OP_POP, OP_CALL, OP_EXC,
      OP_TRDL, OP_TRDH, OP_TWRL, OP_TWRH, OP_FETCH
   } esa_op_e;

   typedef enum logic [1:0] {SPC_DATA, SPC_EXT, SPC_PROG_LO, SPC_PROG_HI} esa_space_e;

   typedef enum {ST_IDLE, ST_PUSH_HI} esa_state_e;

   typedef struct packed {
      logic        valid;
      esa_op_e     op;
      logic        indirect;
      logic [15:0] ea;
      logic [15:0] data;
   } esa_req_s;

   typedef struct packed {
      logic        valid;
      esa_space_e  space;
      logic        write;
      logic        config_sp;
      logic [23:0] addr;
      logic [15:0] data;
      logic        addr_err;
      logic        stack_err;
   } esa_resp_s;

endpackage

// file: esa_addr_gen.sv
// address generation, page translation and stack checking for the core
//
// Functional notes
// [RQ1] indirect address below 8000h ignores both pages and maps to lower data space
// [RQ2] indirect address at or above 8000h with page zero raises address error
// [RQ3] addresses 0000h to 1FFFh are reachable by direct and indirect access
// [RQ4] window write address is write page low 9 bits over ea bits 14..0
// [RQ5] window read with read page bit 9 clear joins 9 page bits over ea
// [RQ6] pages never step by themselves when a pointer wraps FFFFh to 8000h
// [RQ7] stack pointer marks first free word; push post-increments, pop pre-decrements
// [RQ8] call pushes counter with its most significant byte zeroed
// [RQ9] exception push places status word into counter's most significant byte
// [RQ10] stack limit bit 0 stays zero and limit is not cleared by reset
// [RQ11] push at limit is allowed; the next push past it traps
// [RQ12] stack address below 0800h raises stack error
// [RQ13] software should not read through the stack pointer right after limit write
// [RQ14] table address is table page over ea; page bit 7 picks configuration
// [RQ15] program view joins read page low 8 bits over ea bits 14..0
// [RQ16] program view read page bit 8 picks lower or upper program word
// [RQ17] program view drops ea bit 15; address bit 15 is read page bit 0
// [RQ18] program view reaches user memory only and is read-only
// [RQ19] high table instructions use upper word, low ones use lower word
// [RQ20] table reads are allowed in configuration space
// [RQ21] fetch address has bit 23 clear, counter bits 22..1 and bit 0 zero
`timescale 1ns/100ps

module esa_addr_gen (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire esa_pkg::esa_req_s req,
   output wire logic              ready,
   input  wire logic [9:0]        read_page,
   input  wire logic [8:0]        write_page,
   input  wire logic [7:0]        table_page,
   input  wire logic [7:0]        status_word,
   input  wire logic [22:0]       pc,
   input  wire logic              sp_wr,
   input  wire logic [15:0]       sp_wdata,
   input  wire logic              limit_wr,
   input  wire logic [15:0]       limit_wdata,
   output esa_pkg::esa_resp_s     resp,
   output logic [15:0]            stack_pointer_reg,
   output logic [15:0]            stack_limit
);
   import esa_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // lower data space address, upper byte clear
   function automatic logic [23:0] data_addr(input logic [15:0] a);
      data_addr = {ZERO_BYTE, a};
   endfunction

   // extended window address from a 9-bit page
   function automatic logic [23:0] ext_addr(input logic [8:0] pg, input logic [15:0] a);
      ext_addr = {pg, a[WIN_BIT-1:0]};
   endfunction

   // stack fault: past the limit or down in register space
   function automatic logic stack_fault(input logic [15:0] a, input logic [15:0] lim);
      stack_fault = (a > lim) || (a < SFR_TOP);
   endfunction

   esa_state_e  state;
   esa_state_e  next_state;
   esa_resp_s   next_resp;
   logic [15:0] next_sp;
   logic [15:0] frame_hi;
   logic [15:0] pop_ea;

   assign ready  = (state == ST_IDLE);
   assign pop_ea = stack_pointer_reg - WORD_STEP;

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------

   // pages are only read here, never written back
   always_comb begin
      next_resp       = '0;
      next_resp.space = SPC_DATA;
      next_sp         = stack_pointer_reg;
      next_state      = state;
      case (state)
         ST_PUSH_HI: begin
            // second word of a counter frame
            next_resp.valid     = 1'b1;
            next_resp.write     = 1'b1;
            next_resp.addr      = data_addr(stack_pointer_reg);
            next_resp.data      = frame_hi;
            next_resp.stack_err = stack_fault(stack_pointer_reg, stack_limit); // RQ11 RQ12
            if (!next_resp.stack_err) begin
               next_sp = stack_pointer_reg + WORD_STEP; // RQ7
            end
            next_state = ST_IDLE;
         end
         default: begin
            if (req.valid) begin
               next_resp.valid = 1'b1;
               next_resp.data  = req.data;
               case (req.op)
                  OP_READ: begin
                     if (!req.indirect) begin
                        next_resp.addr     = data_addr(req.ea);
                        next_resp.addr_err = (req.ea > NEAR_TOP); // RQ3
                     end else if (!req.ea[WIN_BIT]) begin
                        next_resp.addr = data_addr(req.ea); // RQ1 RQ3
                     end else if (read_page == RPAGE_ZERO) begin
                        next_resp.addr_err = 1'b1; // RQ2
                     end else if (read_page[PV_BIT]) begin
                        // program view, bit 23 left clear so config is unreachable
                        next_resp.addr  = {1'b0, read_page[PV_PAGE_W-1:0],
                                           req.ea[WIN_BIT-1:0]}; // RQ15 RQ17 RQ18
                        next_resp.space = read_page[UPPER_BIT] ? SPC_PROG_HI
                                                               : SPC_PROG_LO; // RQ16
                     end else begin
                        next_resp.addr  = ext_addr(read_page[8:0], req.ea); // RQ5 RQ6
                        next_resp.space = SPC_EXT;
                     end
                  end
                  OP_WRITE: begin
                     next_resp.write = 1'b1;
                     if (!req.indirect) begin
                        next_resp.addr     = data_addr(req.ea);
                        next_resp.addr_err = (req.ea > NEAR_TOP); // RQ3
                     end else if (!req.ea[WIN_BIT]) begin
                        next_resp.addr = data_addr(req.ea); // RQ1
                     end else if (write_page == WPAGE_ZERO) begin
                        next_resp.addr_err = 1'b1; // RQ2
                     end else begin
                        // writes never take the program view path
                        next_resp.addr  = ext_addr(write_page, req.ea); // RQ4 RQ6 RQ18
                        next_resp.space = SPC_EXT;
                     end
                  end
                  OP_PUSH, OP_CALL, OP_EXC: begin
                     next_resp.write     = 1'b1;
                     next_resp.addr      = data_addr(stack_pointer_reg);
                     next_resp.stack_err = stack_fault(stack_pointer_reg,
                                                       stack_limit); // RQ11 RQ12
                     if (req.op != OP_PUSH) begin
                        next_resp.data = {pc[15:0]} & WORD_MASK;
                     end
                     if (!next_resp.stack_err) begin
                        next_sp = stack_pointer_reg + WORD_STEP; // RQ7
                        if (req.op != OP_PUSH) begin
                           next_state = ST_PUSH_HI;
                        end
                     end
                  end
                  OP_POP: begin
                     next_resp.addr      = data_addr(pop_ea);
                     next_resp.stack_err = stack_fault(pop_ea, stack_limit); // RQ12
                     if (!next_resp.stack_err) begin
                        next_sp = pop_ea; // RQ7
                     end
                  end
                  OP_TRDL, OP_TRDH, OP_TWRL, OP_TWRH: begin
                     next_resp.addr      = {table_page, req.ea}; // RQ14
                     next_resp.config_sp = table_page[CFG_BIT]; // RQ14
                     next_resp.write     = (req.op == OP_TWRL) || (req.op == OP_TWRH);
                     next_resp.space     = ((req.op == OP_TRDH) || (req.op == OP_TWRH))
                                           ? SPC_PROG_HI : SPC_PROG_LO; // RQ19
                     // only reads may enter configuration space
                     next_resp.addr_err  = next_resp.write && table_page[CFG_BIT]; // RQ20
                  end
                  OP_FETCH: begin
                     next_resp.addr  = {1'b0, pc[22:1], 1'b0}; // RQ21
                     next_resp.space = SPC_PROG_LO;
                  end
                  default: begin
                     next_resp.addr_err = 1'b1;
                  end
               endcase
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------

   // frame sequencer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // upper frame word captured at the first push
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         frame_hi <= '0;
      end else if (ready && req.valid && (req.op == OP_CALL)) begin
         frame_hi <= {ZERO_BYTE, 1'b0, pc[22:16]}; // RQ8
      end else if (ready && req.valid && (req.op == OP_EXC)) begin
         frame_hi <= {status_word, 1'b0, pc[22:16]}; // RQ9
      end
   end

   // response register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         resp <= '0;
      end else begin
         resp <= next_resp;
      end
   end

   // stack pointer, software write wins over stack traffic
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stack_pointer_reg <= SP_RESET;
      end else if (sp_wr) begin
         stack_pointer_reg <= sp_wdata & WORD_MASK;
      end else begin
         stack_pointer_reg <= next_sp; // RQ7
      end
   end

   // limit holds no reset value on purpose
   always_ff @(posedge sys_clk) begin
      if (limit_wr) begin
         stack_limit <= limit_wdata & WORD_MASK; // RQ10
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   logic idle_req;
   assign idle_req = ready && req.valid;

   near_map_a: assert property ( // RQ1
      idle_req && req.indirect && !req.ea[WIN_BIT] && (req.op == OP_READ)
      |=> resp.valid && !resp.addr_err && (resp.addr == data_addr($past(req.ea))))
      else $error("low indirect read not mapped to data space");

   page_zero_a: assert property ( // RQ2
      idle_req && req.indirect && req.ea[WIN_BIT] && (req.op == OP_WRITE)
      && (write_page == WPAGE_ZERO) |=> resp.addr_err)
      else $error("page zero write did not trap");

   ext_write_a: assert property ( // RQ4
      idle_req && req.indirect && req.ea[WIN_BIT] && (req.op == OP_WRITE)
      && (write_page != WPAGE_ZERO)
      |=> (resp.addr == ext_addr($past(write_page), $past(req.ea))) && (resp.space == SPC_EXT))
      else $error("extended write address wrong");

   ext_read_a: assert property ( // RQ5
      idle_req && req.indirect && req.ea[WIN_BIT] && (req.op == OP_READ)
      && !read_page[PV_BIT] && (read_page != RPAGE_ZERO)
      |=> resp.addr == ext_addr($past(read_page[8:0]), $past(req.ea)))
      else $error("extended read address wrong");

   push_grow_a: assert property ( // RQ7
      idle_req && (req.op == OP_PUSH) && !sp_wr
      && !stack_fault(stack_pointer_reg, stack_limit)
      |=> stack_pointer_reg == $past(stack_pointer_reg) + WORD_STEP)
      else $error("push did not advance stack pointer");

   call_frame_a: assert property ( // RQ8
      idle_req && (req.op == OP_CALL) && !stack_fault(stack_pointer_reg, stack_limit)
      |=> ##1 resp.valid && resp.write && (resp.data[15:8] == ZERO_BYTE))
      else $error("call frame upper byte not clear");

   exc_frame_a: assert property ( // RQ9
      idle_req && (req.op == OP_EXC) && !stack_fault(stack_pointer_reg, stack_limit)
      |=> ##1 resp.data[15:8] == $past(status_word, 2))
      else $error("exception frame lacks status word");

   limit_even_a: assert property ( // RQ10
      $past(limit_wr)
      |-> !stack_limit[0] && (stack_limit == ($past(limit_wdata) & WORD_MASK)))
      else $error("stack limit bit 0 set");

   limit_trap_a: assert property ( // RQ11
      idle_req && (req.op == OP_PUSH) && (stack_pointer_reg > stack_limit)
      |=> resp.stack_err)
      else $error("push past limit did not trap");

   underflow_a: assert property ( // RQ12
      idle_req && (req.op == OP_POP) && (pop_ea < SFR_TOP) |=> resp.stack_err)
      else $error("underflow pop did not trap");

   pv_read_a: assert property ( // RQ15
      idle_req && req.indirect && req.ea[WIN_BIT] && (req.op == OP_READ)
      && read_page[PV_BIT]
      |=> !resp.addr[23] && (resp.addr[15] == $past(read_page[0]))
          && (resp.space == ($past(read_page[UPPER_BIT]) ? SPC_PROG_HI : SPC_PROG_LO)))
      else $error("program view address or word wrong");

   tbl_cfg_a: assert property ( // RQ20
      idle_req && (req.op == OP_TRDH) |=> !resp.addr_err && (resp.space == SPC_PROG_HI))
      else $error("table read refused or wrong word");

   fetch_a: assert property ( // RQ21
      idle_req && (req.op == OP_FETCH)
      |=> resp.addr == {1'b0, $past(pc[22:1]), 1'b0})
      else $error("fetch address wrong");

   call_c:  cover property (idle_req && (req.op == OP_CALL) ##1 state == ST_PUSH_HI);
   pv_c:    cover property (resp.valid && (resp.space == SPC_PROG_HI));
   trap_c:  cover property (resp.valid && resp.addr_err);
   limit_c: cover property (resp.valid && resp.stack_err);

endmodule // esa_addr_gen

// file: esa_core_model.sv
// core-side request model that feeds the stack and address generator
`timescale 1ns/100ps

module esa_core_model
(
   input  wire logic      sys_clk,
   input  wire logic      ready,
   output esa_pkg::esa_req_s req
);
   import esa_pkg::*;

   // --------------------------------------------------------------
   // request driver
   // --------------------------------------------------------------
   initial req = '0;

   // drives one request at the falling edge and holds it through the taking edge
   // the bench never follows a limit load with a stack read in the next cycle
   task automatic issue(input esa_op_e op, input logic ind, input logic [15:0] ea,
                        input logic [15:0] d);
      // one idle edge between requests, so valid is never set twice in one step
      @(negedge sys_clk);
      while (ready !== 1'b1) @(negedge sys_clk);
      req.valid    = 1'b1;
      req.op       = op;
      req.indirect = ind;
      req.ea       = ea;
      req.data     = d;
      @(posedge sys_clk);
      @(negedge sys_clk);
      req.valid    = 1'b0;
      req.ea       = ~ea;   // released address does not keep its old value
   endtask
endmodule // esa_core_model

// file: esa_addr_gen_test.sv
// self-checking bench for the stack and address generator
`timescale 1ns/100ps

module esa_addr_gen_test;
   import esa_pkg::*;

   // --------------------------------------------------------------
   // signals and instances
   // --------------------------------------------------------------
   logic        sys_clk = 1'b0, reset = 1'b1, ready;
   esa_req_s    req;
   esa_resp_s   resp;
   logic [9:0]  read_page = 10'h000;
   logic [8:0]  write_page = 9'h000;
   logic [7:0]  table_page = 8'h00, status_word = 8'h00;
   logic [22:0] pc = 23'h000000;
   logic        sp_wr = 1'b0, limit_wr = 1'b0;
   logic [15:0] sp_wdata = 16'h0000, limit_wdata = 16'h0000;
   logic [15:0] stack_pointer_reg, stack_limit;
   int          err_count = 0, n_checks = 0;

   always #20 sys_clk = ~sys_clk;   // 25 MHz

   esa_core_model core (.sys_clk(sys_clk), .ready(ready), .req(req));

   esa_addr_gen dut (.sys_clk(sys_clk), .reset(reset), .req(req), .ready(ready),
      .read_page(read_page), .write_page(write_page), .table_page(table_page),
      .status_word(status_word), .pc(pc), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
      .limit_wr(limit_wr), .limit_wdata(limit_wdata), .resp(resp),
      .stack_pointer_reg(stack_pointer_reg), .stack_limit(stack_limit));

   // --------------------------------------------------------------
   // compare helpers
   // --------------------------------------------------------------
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // compares a good answer: space, write, config, address, no faults
   task automatic ok(input esa_space_e s, input logic w, input logic c, input logic [23:0] a);
      chk({9'h000, resp.valid, resp.space, resp.write, resp.config_sp, resp.addr,
           resp.addr_err, resp.stack_err}, {9'h000, 1'b1, s, w, c, a, 2'b00});
   endtask

   // compares the valid and fault flags of a refused answer
   task automatic bad(input logic ae, input logic se);
      chk({37'h0, resp.valid, resp.addr_err, resp.stack_err}, {37'h0, 1'b1, ae, se});
   endtask

   task automatic setsp(input logic [15:0] s, input logic [15:0] l);
      sp_wr = 1'b1;
      limit_wr = 1'b1;
      sp_wdata = s;
      limit_wdata = l;
      @(negedge sys_clk);
      sp_wr = 1'b0;
      limit_wr = 1'b0;
   endtask

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_data;
      read_page = 10'h1ff;
      write_page = 9'h1ff;
      core.issue(OP_READ, 1'b1, 16'h1234, 16'h0000); ok(SPC_DATA, 0, 0, 24'h001234);
      core.issue(OP_READ, 1'b0, 16'h1fff, 16'h0000); ok(SPC_DATA, 0, 0, 24'h001fff);
      core.issue(OP_READ, 1'b0, 16'h2000, 16'h0000); bad(1, 0);
      core.issue(OP_WRITE, 1'b1, 16'h8800, 16'h1234); ok(SPC_EXT, 1, 0, 24'hff8800);
      read_page = 10'h002;
      core.issue(OP_READ, 1'b1, 16'h8800, 16'h0000); ok(SPC_EXT, 0, 0, 24'h010800);
      core.issue(OP_READ, 1'b1, 16'hfffe, 16'h0000); ok(SPC_EXT, 0, 0, 24'h017ffe);
      core.issue(OP_READ, 1'b1, 16'h8000, 16'h0000); ok(SPC_EXT, 0, 0, 24'h010000);
      read_page = 10'h000;
      write_page = 9'h000;
      core.issue(OP_READ, 1'b1, 16'h8000, 16'h0000); bad(1, 0);
      core.issue(OP_WRITE, 1'b1, 16'hffff, 16'h0000); bad(1, 0);
      $display("test data done");
   endtask

   task automatic t_prog;
      read_page = 10'h301;
      write_page = 9'h001;
      core.issue(OP_READ, 1'b1, 16'h800a, 16'h0000); ok(SPC_PROG_HI, 0, 0, 24'h00800a);
      read_page = 10'h200;
      core.issue(OP_READ, 1'b1, 16'hffff, 16'h0000); ok(SPC_PROG_LO, 0, 0, 24'h007fff);
      read_page = 10'h3ff;
      core.issue(OP_READ, 1'b1, 16'h0002, 16'h0000); ok(SPC_DATA, 0, 0, 24'h000002);
      core.issue(OP_WRITE, 1'b1, 16'h8004, 16'h0000); ok(SPC_EXT, 1, 0, 24'h008004);
      table_page = 8'h80;
      core.issue(OP_TRDL, 1'b1, 16'h8004, 16'h0000); ok(SPC_PROG_LO, 0, 1, 24'h808004);
      core.issue(OP_TRDH, 1'b1, 16'h0006, 16'h0000); ok(SPC_PROG_HI, 0, 1, 24'h800006);
      core.issue(OP_TWRL, 1'b1, 16'h0006, 16'h0000); bad(1, 0);
      table_page = 8'h7f;
      core.issue(OP_TWRH, 1'b1, 16'hfffe, 16'h0000); ok(SPC_PROG_HI, 1, 0, 24'h7ffffe);
      core.issue(OP_TWRL, 1'b1, 16'h0010, 16'h0000); ok(SPC_PROG_LO, 1, 0, 24'h7f0010);
      pc = 23'h7abcd5;
      core.issue(OP_FETCH, 1'b0, 16'h0000, 16'h0000); ok(SPC_PROG_LO, 0, 0, 24'h7abcd4);
      $display("test program space done");
   endtask

   task automatic t_stack;
      chk({24'h0, stack_pointer_reg}, 40'h0800);
      chk({24'h0, stack_limit}, {24'h0, 16'hxxxx});
      setsp(16'h1000, 16'h1002);
      core.issue(OP_PUSH, 1'b1, 16'h0000, 16'h1111); ok(SPC_DATA, 1, 0, 24'h001000);
      chk({8'h0, resp.data, stack_pointer_reg}, 40'h0011111002);
      core.issue(OP_PUSH, 1'b1, 16'h0000, 16'h2222); ok(SPC_DATA, 1, 0, 24'h001002);
      core.issue(OP_PUSH, 1'b1, 16'h0000, 16'h3333); bad(0, 1);
      chk({24'h0, stack_pointer_reg}, 40'h1004);
      core.issue(OP_POP, 1'b1, 16'h0000, 16'h0000); ok(SPC_DATA, 0, 0, 24'h001002);
      chk({24'h0, stack_pointer_reg}, 40'h1002);
      setsp(16'h0800, 16'h1003);
      chk({24'h0, stack_limit}, 40'h1002);
      core.issue(OP_POP, 1'b1, 16'h0000, 16'h0000); bad(0, 1);
      chk({24'h0, stack_pointer_reg}, 40'h0800);
      $display("test stack done");
   endtask

   task automatic t_call;
      setsp(16'h1000, 16'hfffe);
      pc = 23'h123457;
      status_word = 8'ha5;
      core.issue(OP_CALL, 1'b1, 16'h0000, 16'h0000); ok(SPC_DATA, 1, 0, 24'h001000);
      chk({23'h0, ready, resp.data}, 40'h3456);
      @(negedge sys_clk);
      ok(SPC_DATA, 1, 0, 24'h001002);
      chk({24'h0, resp.data}, 40'h0012);
      core.issue(OP_EXC, 1'b1, 16'h0000, 16'h0000); ok(SPC_DATA, 1, 0, 24'h001004);
      @(negedge sys_clk);
      chk({resp.addr, resp.data}, 40'h001006a512);
      chk({24'h0, stack_pointer_reg}, 40'h1008);
      $display("test call frames done");
   endtask

   // --------------------------------------------------------------
   // run control
   // --------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // main sequence: reset for 16 cycles then each scenario
   initial begin
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      t_data();
      t_prog();
      t_stack();
      t_call();
      finish_test();
   end

   // watchdog well beyond the expected run of under a hundred cycles
   initial begin
      #(40 * 5000);
      err_count++;
      finish_test();
   end
endmodule // esa_addr_gen_test
